/* File: inc/ips_pkg.sv */
// Package for the phase-2 nibble sequencer: register map, nibble constants, timing.
// Assumes a 32-bit AXI4-Lite bus and a 25 MHz clock.
package ips_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int SLOT_US = 228;
  localparam int SLOT_CYCLES = SLOT_US * (CLK_HZ / 1000000);
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CFG_A = 8'h04;
  localparam logic [7:0] OFF_CFG_B = 8'h08;
  localparam logic [7:0] OFF_SERIAL = 8'h0C;
  localparam logic [7:0] OFF_MEAS = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_WORD = 8'h18;
  localparam int CTRL_START = 0;
  localparam int CTRL_EXT = 1;
  localparam int CTRL_SYNC = 2;
  localparam int CTRL_OFS_OK = 3;
  localparam int CTRL_ST_OK = 4;
  localparam int CTRL_DIR = 5;
  localparam int CTRL_RANGE = 7;
  localparam logic [3:0] NIB_REV = 4'h4;
  localparam logic [3:0] NIB_CNT_HI = 4'h2;
  localparam logic [3:0] NIB_CNT_LO = 4'h0;
  localparam logic [3:0] NIB_TYPE_HI = 4'h0;
  localparam logic [3:0] NIB_TYPE_LO = 4'h1;
  localparam logic [3:0] NIB_RANGE_BASE = 4'h7;
  localparam logic [4:0] NIB_LAST = 5'h1F;
  localparam logic [3:0] REP_ASYNC = 4'h8;
  localparam logic [3:0] REP_SYNC = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {IPS_IDLE, IPS_ID, IPS_DATA} ips_state_e;
endpackage

/* File: logic/ips_phase2_seq.sv */
// Phase-2 initialization nibble sequencer, 10-bit mode, with an AXI4-Lite register slave.
// Assumes synchronous inputs and that the frame encoder consumes one word per slot pulse.
// Summary of operation
// RULE1: Nibbles two and three carry block count 0010 then 0000.
// RULE2: First nibble, address 0000, carries protocol revision 0100.
// RULE3: Nibbles six and seven carry sensor type 0000 then 0001.
// RULE4: Nibble eight is axis code from two-bit direction setting, value shifted by two.
// RULE5: With extended enable, nibbles 27-31 carry offset and self-test slices in order.
// RULE6: With extended enable cleared, nibbles 27-32 are sent as 0000.
// RULE7: Offset or self-test nibbles are zero when those results are not ready.
// RULE8: Nibbles 15-18 carry Julian year, month, day from config seven and eight.
// RULE9: Each field repeats k times: 8 asynchronous, 4 synchronous.
// RULE10: Each repetition is two transmissions, identifier then data.
// RULE11: Maker code in nibbles 4-5, config two in 10-11, range code in 9.
// RULE12: Revision nibbles, config six low nibble, then serial bytes high nibble first.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module ips_phase2_seq
  import ips_pkg::*;
#(
  parameter int SLOT_LEN = SLOT_CYCLES,
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] REV_CODE = 8'h11 // Arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] tx_nibble,
  output logic tx_is_data,
  output logic tx_strobe,
  output logic seq_busy
);
  // Registers
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] cfg_a_reg, cfg_a_next;
  logic [31:0] cfg_b_reg, cfg_b_next;
  logic [31:0] serial_reg, serial_next;
  logic [31:0] meas_reg, meas_next;
  logic aw_reg, aw_next, w_reg, w_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic start_pulse;
  // Sequencer state
  ips_state_e state_reg, state_next;
  logic [4:0] idx_reg, idx_next;
  logic [3:0] rep_reg, rep_next;
  logic [31:0] slot_reg, slot_next;
  logic [3:0] nib_reg, nib_next;
  logic isdat_reg, isdat_next;
  logic strobe_reg, strobe_next;
  logic [3:0] data_nib;
  logic [3:0] rep_k;
  logic ext_en, ofs_ok, st_ok;
  logic [9:0] offset_val, selftest_val;
  logic [7:0] cfg1, cfg2, cfg6, cfg7, cfg8;
  logic [6:0] j_year;
  logic [3:0] j_month, j_day;

  assign ext_en = ctrl_reg[CTRL_EXT];
  assign ofs_ok = ctrl_reg[CTRL_OFS_OK];
  assign st_ok = ctrl_reg[CTRL_ST_OK];
  assign cfg1 = cfg_a_reg[7:0];
  assign cfg2 = cfg_a_reg[15:8];
  assign cfg6 = cfg_a_reg[23:16];
  assign cfg7 = cfg_b_reg[7:0];
  assign cfg8 = cfg_b_reg[15:8];
  assign offset_val = meas_reg[9:0];
  assign selftest_val = meas_reg[25:16];
  // Julian form packed across config seven and eight
  assign j_year = cfg7[6:0];
  assign j_month = {cfg7[7], cfg8[7:5]};
  assign j_day = cfg8[3:0];
  assign rep_k = ctrl_reg[CTRL_SYNC] ? REP_SYNC : REP_ASYNC; // [RULE9]

  always_comb begin
    data_nib = 4'h0;
    case (idx_reg)
      5'h00: data_nib = NIB_REV; // [RULE2]
      5'h01: data_nib = NIB_CNT_HI; // [RULE1]
      5'h02: data_nib = NIB_CNT_LO; // [RULE1]
      5'h03: data_nib = MAKER_CODE[7:4]; // [RULE11]
      5'h04: data_nib = MAKER_CODE[3:0]; // [RULE11]
      5'h05: data_nib = NIB_TYPE_HI; // [RULE3]
      5'h06: data_nib = NIB_TYPE_LO; // [RULE3]
      5'h07: data_nib = {ctrl_reg[CTRL_DIR+1], ctrl_reg[CTRL_DIR], 2'b00}; // [RULE4]
      5'h08: data_nib = NIB_RANGE_BASE + {2'b00, ctrl_reg[CTRL_RANGE+1], ctrl_reg[CTRL_RANGE]}; // [RULE11]
      5'h09: data_nib = cfg2[7:4]; // [RULE11]
      5'h0A: data_nib = cfg2[3:0]; // [RULE11]
      5'h0B: data_nib = REV_CODE[7:4]; // [RULE12]
      5'h0C: data_nib = REV_CODE[3:0]; // [RULE12]
      5'h0D: data_nib = cfg6[3:0]; // [RULE12]
      5'h0E: data_nib = j_year[6:3]; // [RULE8]
      5'h0F: data_nib = {j_year[2:0], j_month[3]}; // [RULE8]
      5'h10: data_nib = {j_month[2:0], j_day[1]}; // [RULE8]
      5'h11: data_nib = j_day; // [RULE8]
      5'h12: data_nib = serial_reg[7:4]; // [RULE12]
      5'h13: data_nib = serial_reg[3:0];
      5'h14: data_nib = serial_reg[15:12];
      5'h15: data_nib = serial_reg[11:8];
      5'h16: data_nib = serial_reg[23:20];
      5'h17: data_nib = serial_reg[19:16];
      5'h18: data_nib = serial_reg[31:28];
      5'h19: data_nib = serial_reg[27:24];
      // Unfinished results read as zero [RULE5] [RULE6] [RULE7]
      5'h1A: data_nib = (ext_en && ofs_ok) ? offset_val[3:0] : 4'h0;
      5'h1B: data_nib = (ext_en && ofs_ok) ? offset_val[7:4] : 4'h0;
      5'h1C: data_nib = ext_en ? {st_ok ? selftest_val[1:0] : 2'b00, ofs_ok ? offset_val[9:8] : 2'b00} : 4'h0;
      5'h1D: data_nib = (ext_en && st_ok) ? selftest_val[5:2] : 4'h0;
      5'h1E: data_nib = (ext_en && st_ok) ? selftest_val[9:6] : 4'h0;
      5'h1F: data_nib = ext_en ? cfg1[7:4] : 4'h0; // [RULE6]
      default: data_nib = 4'h0;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    rep_next = rep_reg;
    slot_next = slot_reg;
    nib_next = nib_reg;
    isdat_next = isdat_reg;
    strobe_next = 1'b0;
    case (state_reg)
      IPS_IDLE: begin
        if (start_pulse) begin
          state_next = IPS_ID;
          idx_next = 5'h00;
          rep_next = 4'h0;
          slot_next = 32'h0;
        end
      end
      IPS_ID, IPS_DATA: begin
        if (slot_reg == 32'(SLOT_LEN - 1)) begin
          slot_next = 32'h0;
          strobe_next = 1'b1;
          if (state_reg == IPS_ID) begin
            nib_next = idx_reg[3:0]; // [RULE10]
            isdat_next = 1'b0;
            state_next = IPS_DATA;
          end else begin
            nib_next = data_nib; // [RULE10]
            isdat_next = 1'b1;
            state_next = IPS_ID;
            if (rep_reg == rep_k - 4'h1) begin // [RULE9]
              rep_next = 4'h0;
              if (idx_reg == NIB_LAST) begin
                state_next = IPS_IDLE;
              end else begin
                idx_next = idx_reg + 5'h01;
              end
            end else begin
              rep_next = rep_reg + 4'h1;
            end
          end
        end else begin
          slot_next = slot_reg + 32'h1;
        end
      end
      default: state_next = IPS_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= IPS_IDLE;
      idx_reg <= 5'h00;
      rep_reg <= 4'h0;
      slot_reg <= 32'h0;
      nib_reg <= 4'h0;
      isdat_reg <= 1'b0;
      strobe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      rep_reg <= rep_next;
      slot_reg <= slot_next;
      nib_reg <= nib_next;
      isdat_reg <= isdat_next;
      strobe_reg <= strobe_next;
    end
  end

  assign tx_nibble = nib_reg;
  assign tx_is_data = isdat_reg;
  assign tx_strobe = strobe_reg;
  assign seq_busy = (state_reg != IPS_IDLE);

  // AXI4-Lite slave
  logic wr_fire, rd_fire;
  assign s_axi_awready = !aw_reg && !bvalid_reg;
  assign s_axi_wready = !w_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign wr_fire = aw_reg && w_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && !rvalid_reg;
  assign start_pulse = wr_fire && (awaddr_reg == OFF_CTRL) && wstrb_reg[0] && wdata_reg[CTRL_START];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    aw_next = aw_reg;
    w_next = w_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    ctrl_next = ctrl_reg;
    cfg_a_next = cfg_a_reg;
    cfg_b_next = cfg_b_reg;
    serial_next = serial_reg;
    meas_next = meas_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_next = 1'b1;
      awaddr_next = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_next = 1'b0;
      w_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      case (awaddr_reg)
        OFF_CTRL: ctrl_next = merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_01FE;
        OFF_CFG_A: cfg_a_next = merge(cfg_a_reg, wdata_reg, wstrb_reg);
        OFF_CFG_B: cfg_b_next = merge(cfg_b_reg, wdata_reg, wstrb_reg);
        OFF_SERIAL: serial_next = merge(serial_reg, wdata_reg, wstrb_reg);
        OFF_MEAS: meas_next = merge(meas_reg, wdata_reg, wstrb_reg);
        default: bresp_next = RESP_SLVERR;
      endcase
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        OFF_CTRL: rdata_next = ctrl_reg;
        OFF_CFG_A: rdata_next = cfg_a_reg;
        OFF_CFG_B: rdata_next = cfg_b_reg;
        OFF_SERIAL: rdata_next = serial_reg;
        OFF_MEAS: rdata_next = meas_reg;
        OFF_STATUS: rdata_next = {19'h0, rep_reg, idx_reg, 3'h0, seq_busy};
        OFF_WORD: rdata_next = {27'h0, isdat_reg, nib_reg};
        default: begin
          rdata_next = 32'h0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= 2'h0;
      ctrl_reg <= 32'h0;
      cfg_a_reg <= 32'h0;
      cfg_b_reg <= 32'h0;
      serial_reg <= 32'h0;
      meas_reg <= 32'h0;
    end else begin
      aw_reg <= aw_next;
      w_reg <= w_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      ctrl_reg <= ctrl_next;
      cfg_a_reg <= cfg_a_next;
      cfg_b_reg <= cfg_b_next;
      serial_reg <= serial_next;
      meas_reg <= meas_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Checks
  rev_nibble_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
    (tx_strobe && tx_is_data && $past(idx_reg) == 5'h00 && $past(state_reg) == IPS_DATA) |-> tx_nibble == 4'h4)
    else $error("revision nibble wrong");
  count_nibble_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
    (idx_reg == 5'h01) |-> data_nib == 4'h2)
    else $error("block count high wrong");
  count_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
    (idx_reg == 5'h02) |-> data_nib == 4'h0)
    else $error("block count low wrong");
  type_nibble_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
    (idx_reg == 5'h06) |-> data_nib == 4'h1)
    else $error("sensor type wrong");
  axis_code_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
    (idx_reg == 5'h07) |-> data_nib[1:0] == 2'b00)
    else $error("axis code low bits set");
  ext_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE6]
    (!ext_en && idx_reg >= 5'h1A) |-> data_nib == 4'h0)
    else $error("extended nibble not zero");
  st_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE7]
    (!st_ok && (idx_reg == 5'h1D || idx_reg == 5'h1E)) |-> data_nib == 4'h0)
    else $error("self-test sent before ready");
  // Slot lengths run far past a plain delay, so word spacing is counted here
  logic [31:0] gap_reg, gap_next;
  logic last_id_reg, last_id_next;
  always_comb begin
    gap_next = tx_strobe ? 32'h0 : gap_reg + 32'h1;
    last_id_next = tx_strobe ? !tx_is_data : last_id_reg;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_reg <= 32'h0;
      last_id_reg <= 1'b0;
    end else begin
      gap_reg <= gap_next;
      last_id_reg <= last_id_next;
    end
  end
  id_then_data_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE10]
    (tx_strobe && tx_is_data) |-> (last_id_reg && gap_reg == 32'(SLOT_LEN - 1)))
    else $error("data did not follow identifier");
  data_due_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE10]
    last_id_reg |-> (gap_reg < 32'(SLOT_LEN)))
    else $error("data word overdue after identifier");
  rep_bound_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE9]
    seq_busy |-> rep_reg < rep_k)
    else $error("repeat count overrun");
endmodule

/* File: sim/ips_ecu_model.sv */
// Receiver model for the phase-2 nibble stream: records every word and checks slot spacing.
// Assumes tx_strobe is a one-cycle pulse with nibble and flag valid in the same cycle.
`timescale 1ns/10ps
module ips_ecu_model #(
  parameter int SLOT = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_strobe,
  input wire logic [3:0] tx_nibble,
  input wire logic tx_is_data
);
  logic [4:0] words[$];
  int gap_err = 0;
  int since = 0;

  // Words arrive one per slot; any other spacing is counted
  always @(posedge aclk) begin
    if (aresetn !== 1'b1) begin
      since = 0;
    end else if (tx_strobe === 1'b1) begin
      if (words.size() > 0 && since != SLOT) gap_err++;
      words.push_back({tx_is_data, tx_nibble});
      since = 1;
    end else begin
      since++;
    end
  end
endmodule

/* File: sim/ips_phase2_seq_tb_top.sv */
// Testbench for the phase-2 nibble sequencer: registers over AXI4-Lite, whole sequences checked.
// Assumes the receiver model in ips_ecu_model and a shortened slot length.
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module ips_phase2_seq_tb_top;
  import ips_pkg::*;
  localparam int SL = 4;
  localparam logic [7:0] MK = 8'h3C;  // Arbitrary maker code
  localparam logic [7:0] RV = 8'h96;  // Arbitrary revision code
  localparam logic [31:0] CFG_A = 32'h00A7B6C9;
  localparam logic [31:0] CFG_B = 32'h0000E5D3;
  localparam logic [31:0] SER = 32'h7C5E3A18;
  localparam logic [31:0] MEAS = 32'h01B902D6;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, tx_is_data, tx_strobe, seq_busy;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [3:0] wstrb, tx_nibble;
  logic [1:0] bresp, rresp, rs;
  logic g_ext, g_ofs, g_st;
  logic [1:0] g_dir, g_rng;
  int err_total = 0;
  int num_checks = 0;

  ips_phase2_seq #(.SLOT_LEN(SL), .MAKER_CODE(MK), .REV_CODE(RV)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_nibble(tx_nibble), .tx_is_data(tx_is_data),
    .tx_strobe(tx_strobe), .seq_busy(seq_busy));

  ips_ecu_model #(.SLOT(SL)) ecu (.aclk(aclk), .aresetn(aresetn), .tx_strobe(tx_strobe),
    .tx_nibble(tx_nibble), .tx_is_data(tx_is_data));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic finish_test;
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb, done;
    int n;
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    r = 2'h3;
    done = 1'b0;
    for (n = 0; n < 100 && !done; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      if (tb) r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      done = tb;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr, done;
    int n;
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    r = 2'h3;
    d = 32'h0;
    done = 1'b0;
    for (n = 0; n < 100 && !done; n++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      if (tr) begin
        d = rdata;
        r = rresp;
      end
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      done = tr;
    end
  endtask

  function automatic logic [3:0] exp_nib(input int f);
    logic [6:0] yr;
    logic [3:0] mo, dy;
    logic [9:0] of, st;
    yr = CFG_B[6:0];
    mo = {CFG_B[7], CFG_B[15:13]};
    dy = CFG_B[11:8];
    of = (g_ext && g_ofs) ? MEAS[9:0] : 10'h0;
    st = (g_ext && g_st) ? MEAS[25:16] : 10'h0;
    case (f)
      0: return 4'h4;
      1: return 4'h2;
      3: return MK[7:4];
      4: return MK[3:0];
      6: return 4'h1;
      7: return {g_dir, 2'h0};
      8: return 4'h7 + {2'h0, g_rng};
      9: return CFG_A[15:12];
      10: return CFG_A[11:8];
      11: return RV[7:4];
      12: return RV[3:0];
      13: return CFG_A[19:16];
      14: return yr[6:3];
      15: return {yr[2:0], mo[3]};
      16: return {mo[2:0], dy[1]};
      17: return dy;
      18, 19, 20, 21, 22, 23, 24, 25: return SER[8 * ((f - 18) / 2) + 4 * (1 - (f - 18) % 2) +: 4];
      26: return of[3:0];
      27: return of[7:4];
      28: return {st[1:0], of[9:8]};
      29: return st[5:2];
      30: return st[9:6];
      31: return g_ext ? CFG_A[7:4] : 4'h0;
      default: return 4'h0;
    endcase
  endfunction

  // One full sequence; case 0 also tries a second start while busy, which must be ignored
  task automatic run_case(input int i);
    logic [31:0] c;
    logic [1:0] r;
    logic sync;
    int k, n;
    g_ext = (i != 1);
    g_ofs = (i != 2);
    g_st = (i != 3);
    g_dir = i[1:0];
    g_rng = i[1:0];
    sync = i[0];
    k = sync ? 4 : 8;
    c = {23'h0, g_rng, g_dir, g_st, g_ofs, sync, g_ext, 1'b1};
    ecu.words.delete();
    axi_wr(OFF_CTRL, c, r);
    `CHK(r, RESP_OKAY)
    @(negedge aclk);
    `CHK(seq_busy, 1'b1)
    if (i == 0) begin
      repeat (50) @(posedge aclk);
      axi_wr(OFF_CTRL, c, r);
    end
    for (n = 0; n < 5000 && seq_busy !== 1'b0; n++) @(negedge aclk);
    repeat (2 * SL) @(posedge aclk);
    `CHK(ecu.words.size(), 2 * k * 32)
    `CHK(ecu.gap_err, 0)
    for (n = 0; n < 2 * k * 32; n++) begin
      if (n % 2 == 1)
        `CHK(ecu.words[n], {1'b1, exp_nib(n / (2 * k))})
      else
        `CHK(ecu.words[n], {1'b0, 4'(n / (2 * k))})
    end
    axi_rd(OFF_STATUS, rd, rs);
    `CHK(rd[0], 1'b0)
    axi_rd(OFF_WORD, rd, rs);
    `CHK(rd[4:0], {1'b1, exp_nib(31)})
  endtask

  initial begin
    logic [1:0] r;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
    wstrb = 4'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(OFF_STATUS, rd, rs);
    `CHK(rd, 32'h0)
    `CHK(rs, RESP_OKAY)
    axi_rd(8'h1C, rd, rs);
    `CHK(rs, RESP_SLVERR)
    `CHK(rd, 32'h0)
    axi_wr(8'h20, 32'hFFFF_FFFF, r);
    `CHK(r, RESP_SLVERR)
    axi_wr(OFF_CFG_A, CFG_A, r);
    axi_wr(OFF_CFG_B, CFG_B, r);
    axi_wr(OFF_SERIAL, SER, r);
    axi_wr(OFF_MEAS, MEAS, r);
    for (int i = 0; i < 4; i++) run_case(i);
    finish_test();
  end

  initial begin
    #2000000;
    err_total++;
    finish_test();
  end
endmodule
